// *** rtl/misc_setup.sv ***
// Misc configuration register with clock output divider and diagnostic
// masking, read back as one 22-bit word.
// Assumes the serial interface decodes frames into a one-cycle write
// strobe on sys_clk_in; the fault pin level and the oscillator stop
// flag arrive from outside this clock domain.
`timescale 1ns/1ps

module misc_setup
  import misc_setup_pkg::*;
(
  input  wire logic              sys_clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic              wr_en_in,
  input  wire logic [4:0]        wr_addr_in,
  input  wire logic [WR_WIDTH-1:0] wr_data_in,
  input  wire logic              fault_pin_level_in,
  input  wire logic              osc_stopped_in,
  input  wire logic              range_0_6v_in,
  input  wire logic              range_0_12v_in,
  input  wire logic              clear_req_in,
  input  wire logic              crc_error_in,
  input  wire logic              frame_slip_error_in,
  input  wire logic              clock_count_error_in,
  input  wire logic              other_diag_error_in,
  output logic [REG_WIDTH-1:0]   rd_data_out,
  output logic [1:0]             temp_trip_sel_out,
  output logic [7:0]             temp_trip_degc_out,
  output logic                   clock_output_pin_out,
  output logic                   modem_coupling_enable_out,
  output logic                   shift_0_6v_out,
  output logic                   shift_0_12v_out,
  output logic                   clear_bypass_slew_out,
  output logic                   clear_slewed_out,
  output logic                   digital_diag_summary_out,
  output logic                   serial_fault_out,
  output logic                   stall_code_select_out,
  output logic [23:0]            stall_code_out
);

  // Stored writable bits
  logic [13:0] ctrl;

  // Synchronisers
  logic        fault_meta;
  logic        fault_sync;
  logic        osc_meta;
  logic        osc_sync;

  // Clock output divider
  logic [7:0]  div_count;
  logic        clk_level;

  // Decoded fields
  wire logic        wr_hit;
  wire logic [13:0] next_ctrl;
  wire logic [1:0]  temp_sel;
  wire logic [1:0]  gate_sel;
  wire logic [2:0]  rate_sel;
  wire logic        gate_run;
  wire logic        coupling_en;
  wire logic        shift_en;
  wire logic        immediate_clear_enable;
  wire logic        quiet_en;
  wire logic        stall_en;
  wire logic        serial_errors;
  wire logic        serial_counted;
  wire logic [7:0]  half_count;
  wire logic        div_wrap;
  wire logic [REG_WIDTH-1:0] reg_view;

  // Next values
  wire logic        addr_match;
  wire logic [13:0] wr_field;
  wire logic [7:0]  next_div_count;
  wire logic        next_clk_level;
  wire logic [7:0]  next_trip_degc;
  wire logic        next_shift_0_6v;
  wire logic        next_shift_0_12v;
  wire logic        next_clear_bypass;
  wire logic        next_clear_slewed;
  wire logic        next_diag_summary;
  wire logic        next_stall_select;

  assign addr_match = (wr_addr_in == REG_ADDR);
  assign wr_hit     = wr_en_in && addr_match;
  // Only bits 13:0 take write data
  assign wr_field   = wr_data_in[13:0];
  assign next_ctrl  = wr_hit ? wr_field : ctrl;

  assign temp_sel     = ctrl[TEMP_MSB:TEMP_LSB];
  assign gate_sel     = ctrl[GATE_MSB:GATE_LSB];
  assign rate_sel     = ctrl[RATE_MSB:RATE_LSB];
  assign coupling_en  = ctrl[COUPLING_BIT];
  assign shift_en     = ctrl[SHIFT_BIT];
  assign immediate_clear_enable = ctrl[CLEAR_NOW_BIT];
  assign quiet_en     = ctrl[QUIET_BIT];
  assign stall_en     = ctrl[STALL_BIT];

  // Reserved gate codes are held quiet like code 00
  assign gate_run = (gate_sel == GATE_ON);

  // Read view: fault inverse, address echo, reserved zero, stored bits
  assign reg_view = {~fault_sync, REG_ADDR, 2'h0, ctrl};

  assign serial_errors = crc_error_in
                       | frame_slip_error_in
                       | clock_count_error_in;
  assign serial_counted = serial_errors & ~quiet_en;

  // Next values of the field outputs
  assign next_trip_degc    = TEMP_DEGC[temp_sel];
  assign next_shift_0_6v   = shift_en & range_0_6v_in;
  assign next_shift_0_12v  = shift_en & range_0_12v_in;
  assign next_clear_bypass = clear_req_in & immediate_clear_enable;
  assign next_clear_slewed = clear_req_in & ~immediate_clear_enable;
  assign next_diag_summary = serial_counted
                           | other_diag_error_in;
  assign next_stall_select = stall_en & osc_sync;

  // Half periods fixed at elaboration, so no divider is built
  localparam logic [7:0] HALF_COUNT [8] = '{
    half_period(RATE_KHZ[0]),
    half_period(RATE_KHZ[1]),
    half_period(RATE_KHZ[2]),
    half_period(RATE_KHZ[3]),
    half_period(RATE_KHZ[4]),
    half_period(RATE_KHZ[5]),
    half_period(RATE_KHZ[6]),
    half_period(RATE_KHZ[7])
  };

  assign half_count = HALF_COUNT[rate_sel];

  assign div_wrap       = (div_count >= half_count - 8'h01);
  assign next_div_count = div_wrap ? 8'h00 : div_count + 8'h01;
  assign next_clk_level = div_wrap ? ~clk_level : clk_level;

  // Register storage
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      ctrl <= REG_RESET[13:0];
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // Fault pin level passes two flip-flops; reset to the level that
  // reads as no fault, so bit 21 keeps its reset value after release
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      fault_meta <= ~REG_RESET[FAULT_BIT];
      fault_sync <= ~REG_RESET[FAULT_BIT];
    end else begin
      fault_meta <= fault_pin_level_in;
      fault_sync <= fault_meta;
    end
  end

  // Oscillator stop flag passes two flip-flops
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
    end else begin
      osc_meta <= osc_stopped_in;
      osc_sync <= osc_meta;
    end
  end

  // Clock output divider, held low while gated off
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || !gate_run) begin
      div_count <= 8'h00;
      clk_level <= 1'b0;
    end else begin
      div_count <= next_div_count;
      clk_level <= next_clk_level;
    end
  end

  // Read view; bit 21 follows the fault pin after the two sync stages
  // and this output flip-flop
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      rd_data_out <= REG_RESET;
    end else begin
      rd_data_out <= reg_view;
    end
  end

  // Trip level select
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      temp_trip_sel_out <= 2'h0;
    end else begin
      temp_trip_sel_out <= temp_sel;
    end
  end

  // Trip level in degrees C
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      temp_trip_degc_out <= TEMP_DEGC[0];
    end else begin
      temp_trip_degc_out <= next_trip_degc;
    end
  end

  // Clock output pin; the divider holds it low while the gate is off,
  // so a reserved gate code never lets a clock out
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      clock_output_pin_out <= 1'b0;
    end else begin
      clock_output_pin_out <= clk_level;
    end
  end

  // Coupling capacitor path enable
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      modem_coupling_enable_out <= 1'b0;
    end else begin
      modem_coupling_enable_out <= coupling_en;
    end
  end

  // Below-zero shift of the 0-6 V range; the 0-12 V range gets the same shift bit on its own output
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      shift_0_6v_out <= 1'b0;
    end else begin
      shift_0_6v_out <= next_shift_0_6v;
    end
  end

  // Below-zero shift of the 0-12 V range
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      shift_0_12v_out <= 1'b0;
    end else begin
      shift_0_12v_out <= next_shift_0_12v;
    end
  end

  // Clear that skips slewing; exactly one of the two clear outputs
  // follows a request
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      clear_bypass_slew_out <= 1'b0;
    end else begin
      clear_bypass_slew_out <= next_clear_bypass;
    end
  end

  // Clear that follows the slew
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      clear_slewed_out <= 1'b0;
    end else begin
      clear_slewed_out <= next_clear_slewed;
    end
  end

  // Diagnostic summary; quiet mode leaves the serial error flags out
  // while the other flags still count
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      digital_diag_summary_out <= 1'b0;
    end else begin
      digital_diag_summary_out <= next_diag_summary;
    end
  end

  // Serial error share of the fault pin
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      serial_fault_out <= 1'b0;
    end else begin
      serial_fault_out <= serial_counted;
    end
  end

  // Stall code select on serial data out; the oscillator flag has
  // passed its synchroniser
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      stall_code_select_out <= 1'b0;
    end else begin
      stall_code_select_out <= next_stall_select;
    end
  end

  // Fixed stall code
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      stall_code_out <= STALL_CODE;
    end else begin
      stall_code_out <= STALL_CODE;
    end
  end

endmodule

// *** rtl/misc_setup_pkg.sv ***
// Constants, field layout and clock-out timing of the misc_setup register.
// Assumes a 100 MHz system clock and a register write port of 16 data bits.
package misc_setup_pkg;

  localparam int          CLK_HZ        = 100_000_000;
  localparam int          REG_WIDTH     = 22;
  localparam int          WR_WIDTH      = 16;
  localparam logic [4:0]  REG_ADDR      = 5'h09;
  localparam logic [21:0] REG_RESET     = 22'h090204;
  localparam logic [23:0] STALL_CODE    = 24'h07dead;

  localparam int FAULT_BIT     = 21;
  localparam int ADDR_MSB      = 20;
  localparam int ADDR_LSB      = 16;
  localparam int TEMP_MSB      = 13;
  localparam int TEMP_LSB      = 12;
  localparam int GATE_MSB      = 11;
  localparam int GATE_LSB      = 10;
  localparam int RATE_MSB      = 9;
  localparam int RATE_LSB      = 7;
  localparam int COUPLING_BIT  = 6;
  localparam int SHIFT_BIT     = 5;
  localparam int CLEAR_NOW_BIT = 4;
  localparam int QUIET_BIT     = 3;
  localparam int STALL_BIT     = 2;

  // Bits that a write may change: 13:0
  localparam logic [21:0] WR_MASK = 22'h003fff;

  localparam logic [1:0] GATE_OFF = 2'h0;
  localparam logic [1:0] GATE_ON  = 2'h1;

  // Trip level in degrees C per select code
  localparam logic [7:0] TEMP_DEGC [4] = '{8'h8e, 8'h7f, 8'h70, 8'h61};

  // Clock output rates in kHz per rate code
  localparam int RATE_KHZ [8] = '{416, 435, 454, 476, 500, 526, 555, 588};

  // Half period of the clock output in system clock cycles, rounded
  function automatic logic [7:0] half_period(input int khz);
    int hz2;
    hz2 = 2 * khz * 1000;
    return 8'((CLK_HZ + hz2 / 2) / hz2);
  endfunction

endpackage

// *** bench/misc_setup_checker.sv ***
// Port assertions for misc_setup.
// Assumes a bind into every misc_setup instance.
`timescale 1ns/1ps
module misc_setup_checker (
  input wire logic        sys_clk_in,
  input wire logic        sys_rst_in,
  input wire logic        wr_en_in,
  input wire logic [4:0]  wr_addr_in,
  input wire logic [15:0] wr_data_in,
  input wire logic        fault_pin_level_in,
  input wire logic        crc_error_in,
  input wire logic        frame_slip_error_in,
  input wire logic        clock_count_error_in,
  input wire logic        other_diag_error_in,
  input wire logic [21:0] rd_data_out,
  input wire logic [1:0]  temp_trip_sel_out,
  input wire logic [7:0]  temp_trip_degc_out,
  input wire logic        clock_output_pin_out,
  input wire logic        digital_diag_summary_out,
  input wire logic        serial_fault_out
);
  logic [7:0] hi_cnt;
  logic       err;
  assign err = crc_error_in | frame_slip_error_in | clock_count_error_in;
  always_ff @(posedge sys_clk_in) begin
    hi_cnt <= clock_output_pin_out ? hi_cnt + 8'h01 : 8'h00;
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence hit_s; wr_en_in && wr_addr_in == 5'h09; endsequence
  sequence steady_s; $stable(fault_pin_level_in)[*4]; endsequence
  write_store_a: assert property (hit_s |-> ##2
    rd_data_out[13:0] == $past(wr_data_in[13:0], 2)) else $error("store");
  read_only_a: assert property (rd_data_out[20:14] == 7'h24)
    else $error("read-only bits");
  fault_view_a: assert property (steady_s |->
    rd_data_out[21] != fault_pin_level_in) else $error("fault view");
  trip_level_a: assert property (temp_trip_sel_out == rd_data_out[13:12]
    && temp_trip_degc_out == 8'h8e - 8'h0f * temp_trip_sel_out)
    else $error("trip level");
  gate_idle_a: assert property ((rd_data_out[11:10] != 2'h1)[*3]
    |-> !clock_output_pin_out) else $error("clock while off");
  rate_len_a: assert property ($fell(clock_output_pin_out)
    && rd_data_out[11:10] == 2'h1 && !$past(wr_en_in)
    |-> hi_cnt == 8'h78 - 8'h05 * rd_data_out[9:7]) else $error("rate");
  diag_sum_a: assert property (!$past(sys_rst_in) |->
    digital_diag_summary_out == (($past(err) & !rd_data_out[3])
    | $past(other_diag_error_in))) else $error("summary");
  serial_mask_a: assert property (!$past(sys_rst_in) |->
    serial_fault_out == ($past(err) & !rd_data_out[3])) else $error("mask");
endmodule

bind misc_setup misc_setup_checker chk (.*);

// *** bench/host_model.sv ***
// Host side: issues register writes on the decoded write port.
// Assumes the bench calls write and idle from one process.
`timescale 1ns/1ps
module host_model (
  input  wire logic  sys_clk_in,
  output logic       wr_en_out,
  output logic [4:0] wr_addr_out,
  output logic [15:0] wr_data_out
);
  initial wr_en_out = 1'b0;
  initial wr_addr_out = 5'h00;
  initial wr_data_out = 16'h0000;
  task automatic write(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    wr_en_out <= 1'b1;
    wr_addr_out <= a;
    wr_data_out <= d & 16'h37fc;
  endtask
  task automatic idle();
    @(posedge sys_clk_in);
    wr_en_out <= 1'b0;
    wr_addr_out <= ~wr_addr_out;
    wr_data_out <= ~wr_data_out;
  endtask
endmodule

// *** bench/tb_misc_setup.sv ***
// Bench for misc_setup: writes, field outputs and masks.
// Assumes host_model drives the write port and the checker is bound.
`timescale 1ns/1ps
module tb_misc_setup;
  logic        sys_clk_in = 0;
  logic        sys_rst_in = 1;
  logic        fault = 1;
  logic        osc = 0;
  logic [6:0]  lvl = 0;
  logic        wr_en;
  logic [4:0]  wr_addr;
  logic [15:0] wr_data;
  logic [21:0] rd;
  wire  [7:0]  lv;
  wire  [23:0] stall;
  logic [1:0]  seen_wr = 0;
  logic [13:0] stored = 14'h0204;
  logic [21:0] notes[$];
  int          errors = 0;
  int          checked = 0;
  host_model host (.sys_clk_in(sys_clk_in), .wr_en_out(wr_en),
    .wr_addr_out(wr_addr), .wr_data_out(wr_data));
  misc_setup dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .wr_en_in(wr_en), .wr_addr_in(wr_addr), .wr_data_in(wr_data),
    .fault_pin_level_in(fault), .osc_stopped_in(osc),
    .range_0_6v_in(lvl[6]), .range_0_12v_in(lvl[5]), .clear_req_in(lvl[4]),
    .crc_error_in(lvl[3]), .frame_slip_error_in(lvl[2]),
    .clock_count_error_in(lvl[1]), .other_diag_error_in(lvl[0]),
    .rd_data_out(rd), .temp_trip_sel_out(), .temp_trip_degc_out(),
    .clock_output_pin_out(), .modem_coupling_enable_out(lv[7]),
    .shift_0_6v_out(lv[6]), .shift_0_12v_out(lv[5]),
    .clear_bypass_slew_out(lv[4]), .clear_slewed_out(lv[3]),
    .digital_diag_summary_out(lv[2]), .serial_fault_out(lv[1]),
    .stall_code_select_out(lv[0]), .stall_code_out(stall));
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    if (a == 5'h09) stored = d[13:0] & 14'h37fc;
    notes.push_back({~fault, 5'h09, 2'h0, stored});
    host.write(a, d);
  endtask
  initial forever #5 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) seen_wr <= {seen_wr[0], wr_en & ~sys_rst_in};
  always @(negedge sys_clk_in) begin
    if (seen_wr[1]) check(rd, notes.pop_front());
  end
  initial begin
    #300000;
    errors++;
    give_verdict();
  end
  initial begin
    void'($urandom(45));
    repeat (11) @(posedge sys_clk_in);
    check(rd, 22'h090204);
    @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      wr(5'h09, 16'h0400 | 16'(i << 7) | 16'(i << 12)
        | (16'($urandom) & 16'h007c));
      host.idle();
      repeat (260) @(posedge sys_clk_in);
      wr(5'h09, 16'h0000);
      wr(5'h15, 16'($urandom));
      host.idle();
      repeat (3) @(posedge sys_clk_in);
    end
    for (int m = 0; m < 2; m++) begin
      wr(5'h09, m[0] ? 16'h007c : 16'h0000);
      host.idle();
      repeat (4) begin
        @(posedge sys_clk_in);
        lvl <= 7'($urandom);
        osc <= 1'b1;
        repeat (5) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        check(lv, {m[0], m[0] & lvl[6], m[0] & lvl[5], m[0] & lvl[4],
          ~m[0] & lvl[4], (~m[0] & |lvl[3:1]) | lvl[0],
          ~m[0] & |lvl[3:1], m[0]});
        check(stall, 24'h07dead);
      end
    end
    @(posedge sys_clk_in);
    fault <= 1'b0;
    repeat (6) @(posedge sys_clk_in);
    wr(5'h09, 16'h1234);
    host.idle();
    repeat (4) @(posedge sys_clk_in);
    give_verdict();
  end
endmodule
